// ==== include/tx_desc_dma_regs.vh ====
// register offsets, field positions and reset values of the transmit descriptor list dma
// assumes inclusion by bare name from design and bench files
`ifndef TX_DESC_DMA_REGS_VH
`define TX_DESC_DMA_REGS_VH

// register byte offsets on the ahb-lite slave
`define REG_GLOBAL_MODE 8'h00
`define REG_COMMAND 8'h04
`define REG_BASE_ADDR 8'h08
`define REG_LAST_ADDR 8'h0c
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK 8'h14
`define REG_CHAN_STATUS 8'h18
`define REG_CUR_DESC 8'h1c

// command register bits (write one to issue; init tx only together with action request)
`define CMD_ACTION_REQ 0
`define CMD_INIT_TX 1
`define CMD_TX_POLL 2
`define CMD_TX_RESET 3

// interrupt status bits
`define IRQ_HOST 0
`define IRQ_ERR 1
`define IRQ_FRAME_END 2
`define IRQ_DEACT 3
`define IRQ_BITS 4

// first descriptor word fields
`define DW0_FRAME_END 31
`define DW0_STOP 30
`define DW0_HOST_IRQ 29
`define DW0_COUNT_HI 28
`define DW0_COUNT_LO 16
// completion word flag
`define DW3_COMPLETE 30

// descriptor geometry: words and words fetched by burst
`define DESC_WORDS 4
`define DESC_FETCH_WORDS 8'h03
`define COUNT_MAX 13'h1fff

// reset values
`define RST_GLOBAL_MODE 32'h00000000
`define RST_BASE_ADDR 32'h00000000
`define RST_IRQ_MASK 4'h0

`endif

// ==== src/tx_descriptor_list_dma.v ====
// transmit descriptor list dma channel with ahb-lite register slave and simple memory master
// assumes a single-beat-per-cycle memory port with a read-data valid and write acknowledge
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tx_desc_dma_regs.vh"

module tx_descriptor_list_dma #(
	parameter ADDR_W = 32
) (
	input wire clk,
	input wire sys_rst,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// memory master: request stands until accepted
	output reg memReq,
	output reg memWrite,
	output reg [ADDR_W-1:0] memAddr,
	output reg [7:0] memBurstLen,
	output reg [31:0] memWdata,
	input wire memGrant,
	input wire memRvalid,
	input wire [31:0] memRdata,
	// transmit fifo
	output reg fifoValid,
	output reg [31:0] fifoData,
	output reg [3:0] fifoByteEn,
	output reg fifoFrameEnd,
	input wire fifoReady,
	// interrupt
	output reg irq
);

	// channel states
	localparam ST_IDLE = 3'd0;
	localparam ST_FETCH = 3'd1;
	localparam ST_FETCH_WAIT = 3'd2;
	localparam ST_DATA = 3'd3;
	localparam ST_DATA_WAIT = 3'd4;
	localparam ST_PUSH = 3'd5;
	localparam ST_WB = 3'd6;
	localparam ST_DECIDE = 3'd7;

	// lanes set from a byte offset to the end of the word
	function [3:0] laneFrom;
		input [1:0] off;
		begin
			laneFrom = 4'hf << off;
		end
	endfunction

	// lanes kept for a tail of n bytes (1..4) starting at lane 0
	function [3:0] laneUpTo;
		input [2:0] n;
		begin
			case (n)
				3'd1: laneUpTo = 4'h1;
				3'd2: laneUpTo = 4'h3;
				3'd3: laneUpTo = 4'h7;
				default: laneUpTo = 4'hf;
			endcase
		end
	endfunction

	// software visible registers
	reg chainMode_q; // chaining_mode_select
	reg [31:0] baseAddr_q; // tx_desc_base_address
	reg [31:0] lastAddr_q; // last_tx_desc_address
	reg [`IRQ_BITS-1:0] irqStat_q;
	reg [`IRQ_BITS-1:0] irqMask_q;
	// ahb data phase capture
	reg wrPend_q;
	reg [7:0] wrAddr_q;
	// channel state
	reg [2:0] state_q;
	reg active_q;
	reg [31:0] curDesc_q;
	reg [31:0] nextPtr_q;
	reg [31:0] dataPtr_q;
	reg [12:0] remain_q;
	reg frameEnd_q;
	reg stop_q;
	reg hostIrq_q;
	reg [1:0] wordIdx_q;
	reg redirect_q; // reset/init seen mid descriptor
	reg abort_q; // transmitter reset aborted section
	reg restart_q; // a command is waiting while busy
	reg lastChanged_q; // new last address written while stopped
	reg lastStop_q; // stopped by the last-address compare in mode one
	reg [31:0] wordBuf_q;
	reg [3:0] laneBuf_q;
	reg lastBuf_q;

	// decoded register writes
	wire wrNow = wrPend_q;
	wire [31:0] cmdBits = (wrNow && wrAddr_q == `REG_COMMAND) ? hwdata : 32'h0;
	wire cmdAr = cmdBits[`CMD_ACTION_REQ];
	wire cmdInit = cmdAr && cmdBits[`CMD_INIT_TX];
	wire cmdPoll = cmdBits[`CMD_TX_POLL];
	wire cmdReset = cmdBits[`CMD_TX_RESET];
	wire lastWrite = wrNow && wrAddr_q == `REG_LAST_ADDR;
	// bytes left in the current word from the data pointer
	wire [2:0] wordRoom = 3'd4 - {1'b0, dataPtr_q[1:0]};
	wire lastWord = {10'h0, wordRoom} >= remain_q;
	wire [2:0] tailBytes = remain_q[2:0] + {1'b0, dataPtr_q[1:0]};

	// event pulses into the interrupt status
	reg [`IRQ_BITS-1:0] evt;

	// ahb-lite slave, zero wait state, always okay
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wrPend_q <= 1'b0;
			if (hsel && hready && htrans[1]) begin
				wrPend_q <= hwrite;
				wrAddr_q <= haddr[7:0];
				// read data registered for the data phase; unmapped reads zero
				case (haddr[7:0])
					`REG_GLOBAL_MODE: hrdata <= {31'h0, chainMode_q};
					`REG_BASE_ADDR: hrdata <= baseAddr_q;
					`REG_LAST_ADDR: hrdata <= lastAddr_q;
					`REG_IRQ_STATUS: hrdata <= {28'h0, irqStat_q};
					`REG_IRQ_MASK: hrdata <= {28'h0, irqMask_q};
					`REG_CHAN_STATUS: hrdata <= {25'h0, state_q, 3'h0, active_q};
					`REG_CUR_DESC: hrdata <= curDesc_q;
					default: hrdata <= 32'h0;
				endcase
			end
		end
	end

	// configuration registers
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chainMode_q <= 1'b0;
			baseAddr_q <= `RST_BASE_ADDR;
			lastAddr_q <= 32'h0;
			irqMask_q <= `RST_IRQ_MASK;
		end else if (wrNow) begin
			case (wrAddr_q)
				`REG_GLOBAL_MODE: chainMode_q <= hwdata[0];
				`REG_BASE_ADDR: baseAddr_q <= {hwdata[31:2], 2'b00};
				`REG_LAST_ADDR: lastAddr_q <= {hwdata[31:2], 2'b00};
				`REG_IRQ_MASK: irqMask_q <= hwdata[`IRQ_BITS-1:0];
				default: ;
			endcase
		end
	end

	// sticky status: set wins over write-one-to-clear
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqStat_q <= {`IRQ_BITS{1'b0}};
			irq <= 1'b0;
		end else begin
			if (wrNow && wrAddr_q == `REG_IRQ_STATUS)
				irqStat_q <= (irqStat_q & ~hwdata[`IRQ_BITS-1:0]) | evt;
			else
				irqStat_q <= irqStat_q | evt;
			irq <= |(irqStat_q & irqMask_q);
		end
	end

	// channel sequencer
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			active_q <= 1'b0;
			curDesc_q <= 32'h0;
			nextPtr_q <= 32'h0;
			dataPtr_q <= 32'h0;
			remain_q <= 13'h0;
			frameEnd_q <= 1'b0;
			stop_q <= 1'b0;
			hostIrq_q <= 1'b0;
			wordIdx_q <= 2'd0;
			redirect_q <= 1'b0;
			abort_q <= 1'b0;
			restart_q <= 1'b0;
			lastChanged_q <= 1'b0;
			lastStop_q <= 1'b0;
			wordBuf_q <= 32'h0;
			laneBuf_q <= 4'h0;
			lastBuf_q <= 1'b0;
			memReq <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= {ADDR_W{1'b0}};
			memBurstLen <= 8'h0;
			memWdata <= 32'h0;
			fifoValid <= 1'b0;
			fifoData <= 32'h0;
			fifoByteEn <= 4'h0;
			fifoFrameEnd <= 1'b0;
			evt <= {`IRQ_BITS{1'b0}};
		end else begin
			evt <= {`IRQ_BITS{1'b0}};
			if (lastWrite)
				lastChanged_q <= 1'b1;
			// reset or init while a descriptor is in flight
			if (state_q != ST_IDLE && (cmdReset || cmdInit))
				redirect_q <= 1'b1;
			if (state_q != ST_IDLE && cmdReset && state_q != ST_WB && state_q != ST_DECIDE)
				abort_q <= 1'b1;
			if (state_q != ST_IDLE && (cmdAr || cmdPoll))
				restart_q <= 1'b1;
			if (fifoValid && fifoReady)
				fifoValid <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// fetch on command, or in mode one on a new last address after a compare stop
					if (cmdInit || (cmdAr && !active_q)) begin
						curDesc_q <= baseAddr_q;
						active_q <= 1'b1;
						lastStop_q <= 1'b0;
						state_q <= ST_FETCH;
					end else if (cmdPoll || cmdAr) begin
						active_q <= 1'b1;
						lastStop_q <= 1'b0;
						state_q <= ST_FETCH;
					end else if (lastStop_q && chainMode_q && lastChanged_q) begin
						// new last address after a compare stop: go on past the stopped one
						lastChanged_q <= lastWrite;
						lastStop_q <= 1'b0;
						active_q <= 1'b1;
						curDesc_q <= nextPtr_q;
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					// one burst of the first three words
					memReq <= 1'b1;
					memWrite <= 1'b0;
					memAddr <= curDesc_q[ADDR_W-1:0];
					memBurstLen <= `DESC_FETCH_WORDS;
					wordIdx_q <= 2'd0;
					state_q <= ST_FETCH_WAIT;
				end
				ST_FETCH_WAIT: begin
					if (memGrant)
						memReq <= 1'b0;
					if (memRvalid) begin
						wordIdx_q <= wordIdx_q + 2'd1;
						case (wordIdx_q)
							2'd0: begin
								frameEnd_q <= memRdata[`DW0_FRAME_END];
								stop_q <= memRdata[`DW0_STOP];
								hostIrq_q <= memRdata[`DW0_HOST_IRQ];
								remain_q <= memRdata[`DW0_COUNT_HI:`DW0_COUNT_LO];
							end
							2'd1: nextPtr_q <= memRdata;
							default: begin
								dataPtr_q <= memRdata;
								if (remain_q == 13'h0) begin
									// nothing to send: error, or a bare frame end
									if (!frameEnd_q)
										evt[`IRQ_ERR] <= 1'b1;
									else begin
										fifoValid <= 1'b1;
										fifoByteEn <= 4'h0;
										fifoFrameEnd <= 1'b1;
										evt[`IRQ_FRAME_END] <= 1'b1;
									end
									state_q <= ST_WB;
								end else
									state_q <= ST_DATA;
							end
						endcase
					end
				end
				ST_DATA: begin
					if (abort_q) begin
						state_q <= ST_WB;
					end else begin
						// word-aligned read of the word holding the next byte
						memReq <= 1'b1;
						memWrite <= 1'b0;
						memAddr <= {dataPtr_q[ADDR_W-1:2], 2'b00};
						memBurstLen <= 8'd1;
						laneBuf_q <= lastWord ? (laneFrom(dataPtr_q[1:0]) & laneUpTo(tailBytes))
							: laneFrom(dataPtr_q[1:0]);
						lastBuf_q <= lastWord;
						state_q <= ST_DATA_WAIT;
					end
				end
				ST_DATA_WAIT: begin
					if (memGrant)
						memReq <= 1'b0;
					if (memRvalid) begin
						wordBuf_q <= memRdata;
						state_q <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					// hand word to fifo once it has room; stalls on back-pressure
					if (!fifoValid || fifoReady) begin
						fifoValid <= 1'b1;
						fifoData <= wordBuf_q;
						fifoByteEn <= laneBuf_q;
						fifoFrameEnd <= lastBuf_q && frameEnd_q;
						if (lastBuf_q) begin
							remain_q <= 13'h0;
							if (frameEnd_q)
								evt[`IRQ_FRAME_END] <= 1'b1;
							state_q <= ST_WB;
						end else begin
							remain_q <= remain_q - {10'h0, wordRoom};
							dataPtr_q <= {dataPtr_q[31:2] + 30'h1, 2'b00};
							state_q <= ST_DATA;
						end
					end
				end
				ST_WB: begin
					// completion word is the fourth of the descriptor
					if (!memReq) begin
						memReq <= 1'b1;
						memWrite <= 1'b1;
						memAddr <= curDesc_q[ADDR_W-1:0] + `DESC_WORDS * 4 - 4;
						memBurstLen <= 8'd1;
						memWdata <= 32'h1 << `DW3_COMPLETE;
					end else if (memGrant) begin
						memReq <= 1'b0;
						memWrite <= 1'b0;
						if (hostIrq_q && !abort_q)
							evt[`IRQ_HOST] <= 1'b1;
						state_q <= ST_DECIDE;
					end
				end
				ST_DECIDE: begin
					abort_q <= 1'b0;
					redirect_q <= 1'b0;
					if (redirect_q || cmdReset || cmdInit) begin
						curDesc_q <= baseAddr_q;
						restart_q <= 1'b0;
						state_q <= ST_FETCH;
					end else if (!chainMode_q ? !stop_q : (curDesc_q != lastAddr_q)) begin
						curDesc_q <= nextPtr_q;
						state_q <= ST_FETCH;
					end else if ((restart_q || cmdAr || cmdPoll) && !chainMode_q) begin
						restart_q <= 1'b0;
						curDesc_q <= nextPtr_q;
						state_q <= ST_FETCH;
					end else begin
						// stop flag counts only in mode zero; last compare only in mode one
						active_q <= 1'b0;
						restart_q <= 1'b0;
						lastChanged_q <= lastWrite; // a write in this very cycle still counts
						lastStop_q <= chainMode_q; // only mode one waits for a new last address
						evt[`IRQ_DEACT] <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== verification/tx_mem_model.sv ====
// shared memory model answering descriptor, data and completion requests
// assumes one outstanding request at a time from the dma memory port
`timescale 1ns/1ps
`default_nettype none
module tx_mem_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [31:0] memAddr,
	input wire logic [7:0] memBurstLen,
	input wire logic [31:0] memWdata,
	output logic memGrant,
	output logic memRvalid,
	output logic [31:0] memRdata
);
	logic [31:0] mem [0:255]; // four words per descriptor
	logic [7:0] left; // burst words still owed
	logic [7:0] ra; // next word index
	logic stall; // delays grants when slow
	initial begin
		memGrant = 1'b0;
		memRvalid = 1'b0;
		memRdata = 32'h0;
		left = 8'h0;
		stall = 1'b0;
	end
	// grant, then stream words; idle data toggles
	always @(posedge clk) begin
		memGrant <= 1'b0;
		memRvalid <= 1'b0;
		memRdata <= ~memRdata;
		stall <= ~stall;
		if (left != 8'h0) begin
			memRvalid <= 1'b1; // burst words in order
			memRdata <= mem[ra];
			ra <= ra + 8'h1;
			left <= left - 8'h1;
		end else if (memReq && !memGrant && !(slow && stall)) begin
			memGrant <= 1'b1;
			if (memWrite)
				mem[memAddr[9:2]] <= memWdata; // completion word
			else begin
				ra <= memAddr[9:2];
				left <= memBurstLen;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/tx_dma_chk_sva.sv ====
// checker of memory and fifo port behaviour of the dma
// assumes binding onto the dma top module
`timescale 1ns/1ps
`default_nettype none
module tx_dma_chk #(
	parameter ADDR_W = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic [7:0] memBurstLen,
	input wire logic [31:0] memWdata,
	input wire logic memGrant,
	input wire logic fifoValid,
	input wire logic fifoReady,
	input wire logic [31:0] fifoData,
	input wire logic [3:0] fifoByteEn,
	input wire logic fifoFrameEnd
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [ADDR_W-1:0] fetchAddr_q; // last granted descriptor fetch
	// remember descriptor address of each fetch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			fetchAddr_q <= '0;
		else if (memReq && memGrant && memBurstLen == 8'h03)
			fetchAddr_q <= memAddr;
	end
	sequence s_reqWait;
		memReq && !memGrant;
	endsequence
	sequence s_reqDone;
		memReq && memGrant;
	endsequence
	sequence s_fifoWait;
		fifoValid && !fifoReady;
	endsequence
	property p_slaveOk;
		hreadyout && !hresp;
	endproperty
	a_slaveOk: assert property (p_slaveOk) else $error("slave not ready or error");
	property p_reqHold;
		s_reqWait |=> memReq && $stable(memAddr) && $stable(memWrite) && $stable(memBurstLen);
	endproperty
	a_reqHold: assert property (p_reqHold) else $error("request changed before grant");
	property p_fetchAlign;
		memReq && !memWrite && memBurstLen == 8'h03 |-> memAddr[1:0] == 2'b00;
	endproperty
	a_fetchAlign: assert property (p_fetchAlign) else $error("fetch unaligned");
	property p_wbWord;
		memReq && memWrite |-> memWdata == 32'h40000000 && memBurstLen == 8'h01;
	endproperty
	a_wbWord: assert property (p_wbWord) else $error("bad completion word");
	property p_wbAddr;
		memReq && memWrite |-> memAddr == fetchAddr_q + 12;
	endproperty
	a_wbAddr: assert property (p_wbAddr) else $error("completion not at fourth word");
	property p_dataLen;
		memReq && !memWrite && memBurstLen != 8'h03 |-> memBurstLen == 8'h01 && memAddr[1:0] == 2'b00;
	endproperty
	a_dataLen: assert property (p_dataLen) else $error("data read not a word");
	property p_grantDrop;
		s_reqDone |=> !memReq || $changed(memAddr);
	endproperty
	a_grantDrop: assert property (p_grantDrop) else $error("request repeated");
	property p_fifoHold;
		s_fifoWait |=> fifoValid && $stable(fifoData) && $stable(fifoByteEn) && $stable(fifoFrameEnd);
	endproperty
	a_fifoHold: assert property (p_fifoHold) else $error("fifo beat changed");
endmodule
bind tx_descriptor_list_dma tx_dma_chk #(.ADDR_W(ADDR_W)) u_tx_dma_chk (.clk(clk), .sys_rst(sys_rst),
	.hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
	.memBurstLen(memBurstLen), .memWdata(memWdata), .memGrant(memGrant), .fifoValid(fifoValid),
	.fifoReady(fifoReady), .fifoData(fifoData), .fifoByteEn(fifoByteEn), .fifoFrameEnd(fifoFrameEnd));
`default_nettype wire

// ==== verification/tb_top.sv ====
// testbench: ahb-lite register tasks, memory model, fifo sink
// assumes the register map header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "tx_desc_dma_regs.vh"
module tb_top;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, memReq, memWrite, memGrant, memRvalid;
	logic fifoValid, fifoFrameEnd, fifoReady, irq, slow;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, memAddr, memWdata, memRdata, fifoData, rd;
	logic [7:0] memBurstLen;
	logic [3:0] fifoByteEn;
	logic [36:0] beats [$]; // data, lanes, frame end
	int err_total, comparisons, grants, g;
	always #5 clk = ~clk;
	tx_descriptor_list_dma #(.ADDR_W(32)) u_tx_descriptor_list_dma (.clk(clk), .sys_rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memWrite(memWrite),
		.memAddr(memAddr), .memBurstLen(memBurstLen), .memWdata(memWdata), .memGrant(memGrant),
		.memRvalid(memRvalid), .memRdata(memRdata), .fifoValid(fifoValid), .fifoData(fifoData),
		.fifoByteEn(fifoByteEn), .fifoFrameEnd(fifoFrameEnd), .fifoReady(fifoReady), .irq(irq));
	tx_mem_model u_tx_mem_model (.clk(clk), .slow(slow), .memReq(memReq), .memWrite(memWrite),
		.memAddr(memAddr), .memBurstLen(memBurstLen), .memWdata(memWdata), .memGrant(memGrant),
		.memRvalid(memRvalid), .memRdata(memRdata));
	// stalling fifo sink and grant counter
	always @(posedge clk) begin
		fifoReady <= ~fifoReady;
		if (fifoValid && fifoReady)
			beats.push_back({fifoData, fifoByteEn, fifoFrameEnd});
		if (memGrant)
			grants++;
	end
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hwait;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			print_verdict;
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		hwait;
		htrans <= 2'b00;
		hwdata <= d;
		hwait;
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(a, 1'b0, 32'h0);
		chk(nm, {5'h0, rd}, {5'h0, e});
	endtask
	task automatic wdone(input int i);
		int n;
		n = 0;
		while (u_tx_mem_model.mem[i] !== 32'h40000000 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			print_verdict;
		end
		repeat (30) @(posedge clk);
	endtask
	initial begin
		clk = 0; rst = 1; hsel = 1; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010; hwdata = 0;
		fifoReady = 0; slow = 1; err_total = 0; comparisons = 0; grants = 0;
		for (int i = 0; i < 256; i++)
			u_tx_mem_model.mem[i] = {4{i[7:0]}};
		u_tx_mem_model.mem[64] = 32'ha0060000; // frame end, host irq, six bytes
		u_tx_mem_model.mem[65] = 32'h110;
		u_tx_mem_model.mem[66] = 32'h201;
		u_tx_mem_model.mem[68] = 32'h40000000; // stop, no bytes, no frame end
		u_tx_mem_model.mem[72] = 32'h40040000; // stop ignored in mode one
		u_tx_mem_model.mem[73] = 32'h130;
		u_tx_mem_model.mem[74] = 32'h300;
		u_tx_mem_model.mem[76] = 32'h80040000;
		u_tx_mem_model.mem[77] = 32'h100;
		u_tx_mem_model.mem[78] = 32'h304;
		u_tx_mem_model.mem[67] = 0;
		u_tx_mem_model.mem[71] = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(`REG_IRQ_MASK, {28'h0, `RST_IRQ_MASK}, "mask reset");
		rchk(`REG_GLOBAL_MODE, `RST_GLOBAL_MODE, "mode reset");
		bus(8'h40, 1'b1, 32'hffffffff);
		rchk(8'h40, 32'h0, "unmapped");
		bus(`REG_BASE_ADDR, 1'b1, 32'h100);
		rchk(`REG_BASE_ADDR, 32'h100, "base");
		$display("register test done");
		bus(`REG_COMMAND, 1'b1, 32'h1);
		wdone(71);
		chk("complete a", u_tx_mem_model.mem[67], 32'h40000000);
		chk("beats", beats.size(), 2);
		chk("beat0", beats[0], {u_tx_mem_model.mem[128], 4'b1110, 1'b0});
		chk("beat1", beats[1], {u_tx_mem_model.mem[129], 4'b0111, 1'b1});
		chk("irq masked", irq, 1'b0);
		rchk(`REG_IRQ_STATUS, 32'hf, "status");
		rchk(`REG_CHAN_STATUS, 32'h0, "inactive");
		g = grants;
		bus(`REG_IRQ_MASK, 1'b1, 32'hf);
		repeat (60) @(posedge clk);
		chk("no reads", grants, g);
		chk("irq on", irq, 1'b1);
		bus(`REG_IRQ_STATUS, 1'b1, 32'hf);
		repeat (3) @(posedge clk);
		chk("irq off", irq, 1'b0);
		$display("mode zero test done");
		bus(`REG_COMMAND, 1'b1, 32'h4);
		repeat (80) @(posedge clk);
		chk("poll grants", grants, g + 2);
		rchk(`REG_IRQ_STATUS, 32'ha, "poll status");
		$display("poll test done");
		u_tx_mem_model.mem[67] = 0;
		bus(`REG_GLOBAL_MODE, 1'b1, 32'h1);
		bus(`REG_BASE_ADDR, 1'b1, 32'h120);
		bus(`REG_LAST_ADDR, 1'b1, 32'h130);
		bus(`REG_COMMAND, 1'b1, 32'h3);
		wdone(79);
		chk("complete c", u_tx_mem_model.mem[75], 32'h40000000);
		chk("no branch", u_tx_mem_model.mem[67], 32'h0);
		chk("beats", beats.size(), 4);
		chk("beat2", beats[2], {u_tx_mem_model.mem[192], 4'hf, 1'b0});
		chk("beat3", beats[3], {u_tx_mem_model.mem[193], 4'hf, 1'b1});
		bus(`REG_LAST_ADDR, 1'b1, 32'h100);
		wdone(67);
		chk("relaunch beats", beats.size(), 6);
		chk("beat5", beats[5], {u_tx_mem_model.mem[129], 4'b0111, 1'b1});
		rchk(`REG_CHAN_STATUS, 32'h0, "stopped at last");
		$display("mode one test done");
		print_verdict;
	end
endmodule
`default_nettype wire
